// >>> acif_ctrl.sv
module acif_ctrl #(
	parameter int SCAN_CYCLES = acif_pkg::SCAN_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	acif_link_if.ctrl link,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	function automatic logic mapped(input logic [7:0] a);
		return a == acif_pkg::OFS_CTRL || a == acif_pkg::OFS_FILTER || a == acif_pkg::OFS_INPUTS
			|| a == acif_pkg::OFS_STATUS || a == acif_pkg::OFS_TBEVT;
	endfunction

	logic awready_reg, awready_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] ctrl_reg, ctrl_next;
	logic [6:0] setting_reg, setting_next;
	logic [1:0] tbSticky_reg, tbSticky_next;
	logic tbPresent_reg, tbPresent_next;
	logic [31:0] scanCount_reg, scanCount_next;
	logic scanPulse_reg, scanPulse_next;

	always_comb begin
		logic wrDo;
		logic rdDo;
		wrDo = awready_reg && s_axi_awvalid && s_axi_wvalid;
		rdDo = arready_reg && s_axi_arvalid;
		awready_next = s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
		arready_next = s_axi_arvalid && !arready_reg && !rvalid_reg;
		bvalid_next = bvalid_reg && !s_axi_bready;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg && !s_axi_rready;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		ctrl_next = ctrl_reg;
		setting_next = setting_reg;
		tbSticky_next = tbSticky_reg;
		tbPresent_next = tbPresent_reg;
		if (wrDo) begin
			bvalid_next = 1'b1;
			bresp_next = mapped(s_axi_awaddr) ? acif_pkg::RESP_OKAY : acif_pkg::RESP_SLVERR;
			if (s_axi_wstrb[0]) begin
				if (s_axi_awaddr == acif_pkg::OFS_CTRL)
					ctrl_next = s_axi_wdata[1:0];
				if (s_axi_awaddr == acif_pkg::OFS_FILTER && s_axi_wdata[6:0] >= acif_pkg::SET_MIN
					&& s_axi_wdata[31:7] == '0)
					setting_next = s_axi_wdata[6:0]; // R4
				if (s_axi_awaddr == acif_pkg::OFS_TBEVT)
					tbSticky_next = tbSticky_reg & ~s_axi_wdata[1:0];
			end
		end
		if (link.tbEvent) begin // R12
			tbPresent_next = link.tbAttach;
			if (link.tbAttach)
				tbSticky_next[acif_pkg::TB_ATTACH] = 1'b1;
			else
				tbSticky_next[acif_pkg::TB_LOSS] = 1'b1;
		end
		if (rdDo) begin
			rvalid_next = 1'b1;
			rresp_next = mapped(s_axi_araddr) ? acif_pkg::RESP_OKAY : acif_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				acif_pkg::OFS_CTRL: rdata_next = {30'h0, ctrl_reg};
				acif_pkg::OFS_FILTER: rdata_next = {25'h0, setting_reg};
				acif_pkg::OFS_INPUTS: rdata_next = link.inputState;
				acif_pkg::OFS_STATUS: rdata_next = {16'h0, link.statusWord};
				acif_pkg::OFS_TBEVT: rdata_next = {29'h0, tbPresent_reg, tbSticky_reg};
				default: rdata_next = '0;
			endcase
		end
		scanPulse_next = 1'b0;
		scanCount_next = scanCount_reg + 32'h0000_0001;
		if (scanCount_reg == 32'(SCAN_CYCLES - 1)) begin
			scanCount_next = '0;
			scanPulse_next = 1'b1; // R6
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			awready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= acif_pkg::RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= acif_pkg::RESP_OKAY;
			rdata_reg <= '0;
			ctrl_reg <= '0;
			setting_reg <= acif_pkg::SET_RESET;
			tbSticky_reg <= '0;
			tbPresent_reg <= 1'b0;
			scanCount_reg <= '0;
			scanPulse_reg <= 1'b0;
		end else begin
			awready_reg <= awready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			setting_reg <= setting_next;
			tbSticky_reg <= tbSticky_next;
			tbPresent_reg <= tbPresent_next;
			scanCount_reg <= scanCount_next;
			scanPulse_reg <= scanPulse_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = awready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign link.filterLen = ctrl_reg[acif_pkg::CTRL_FILT_EN] ? acif_pkg::LEN_ON : acif_pkg::LEN_OFF; // R3
	assign link.statusLen = ctrl_reg[acif_pkg::CTRL_STAT_EN] ? acif_pkg::LEN_ON : acif_pkg::LEN_OFF; // R8
	assign link.filterSetting = setting_reg;
	assign link.settingValid = scanPulse_reg;

endmodule

// >>> acif_device.sv
// Overview of operation
// R1: sample 32 inputs, four groups of eight
// R2: filter time 20 to 2540 ms, 20 ms steps
// R3: filter length 16 enables, 0 disables
// R4: controller writes settings only 1 to 127
// R5: setting times twenty gives filter milliseconds
// R6: controller sends setting every scan
// R7: extra AC-cycle delay beyond filter time
// R8: status word sent only when length 16
// R9: status uses only low eleven bits
// R10: status bit 9 high means not ready
// R11: terminal block indicator green latched, else red
// R12: message on terminal block attach and loss
// R13: one indicator per input point
// R14: change reported after holding filter time
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
module acif_device #(
	parameter int MS_CYCLES = acif_pkg::MS_CYCLES,
	parameter int AC_MS = acif_pkg::AC_MS
) (
	input wire logic clock,
	input wire logic rst,
	acif_link_if.device link,
	input wire logic [31:0] rawIn,
	input wire logic tbLatched,
	output logic [31:0] pointLed,
	output logic tbLedGreen,
	output logic tbLedRed
);

	function automatic logic [11:0] extraAc(input int ms);
		int n;
		if (ms <= acif_pkg::EXTRA_MS_0)
			n = 0;
		else if (ms <= acif_pkg::EXTRA_MS_1)
			n = 1;
		else if (ms < acif_pkg::EXTRA_MS_2)
			n = 2;
		else
			n = 3;
		return 12'(n * AC_MS);
	endfunction

	function automatic logic [11:0] holdMs(input logic [6:0] setting);
		int ms;
		ms = int'(setting) * acif_pkg::FILT_STEP_MS;
		return 12'(ms) + extraAc(ms);
	endfunction

	// millisecond time base
	logic [31:0] msCount_reg, msCount_next;
	logic msTick_reg, msTick_next;

	always_comb begin
		msTick_next = 1'b0;
		msCount_next = msCount_reg + 32'h0000_0001;
		if (msCount_reg == 32'(MS_CYCLES - 1)) begin
			msCount_next = '0;
			msTick_next = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			msCount_reg <= '0;
			msTick_reg <= 1'b0;
		end else begin
			msCount_reg <= msCount_next;
			msTick_reg <= msTick_next;
		end
	end

	// filter configuration from the controller
	logic [6:0] setting_reg, setting_next;
	logic haveSetting_reg, haveSetting_next;
	logic filterOn_reg, filterOn_next;
	logic [11:0] hold_reg, hold_next;

	always_comb begin
		setting_next = setting_reg;
		haveSetting_next = haveSetting_reg;
		if (link.settingValid && link.filterSetting >= acif_pkg::SET_MIN) begin // R6
			setting_next = link.filterSetting; // R4
			haveSetting_next = 1'b1;
		end
		filterOn_next = (link.filterLen == acif_pkg::LEN_ON) && haveSetting_reg; // R3
		hold_next = holdMs(setting_reg); // R2 R5 R7
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			setting_reg <= acif_pkg::SET_RESET;
			haveSetting_reg <= 1'b0;
			filterOn_reg <= 1'b0;
			hold_reg <= '0;
		end else begin
			setting_reg <= setting_next;
			haveSetting_reg <= haveSetting_next;
			filterOn_reg <= filterOn_next;
			hold_reg <= hold_next;
		end
	end

	// per-point qualification, four groups of eight share one time base
	logic [31:0] stable_reg, stable_next;
	logic [11:0] count_reg [acif_pkg::POINTS];
	logic [11:0] count_next [acif_pkg::POINTS];

	always_comb begin
		for (int i = 0; i < acif_pkg::POINTS; i++) begin // R1
			stable_next[i] = stable_reg[i];
			count_next[i] = count_reg[i];
			if (!filterOn_reg) begin
				stable_next[i] = rawIn[i]; // R3
				count_next[i] = '0;
			end else if (rawIn[i] == stable_reg[i]) begin
				count_next[i] = '0; // R14
			end else if (msTick_reg) begin
				if (count_reg[i] + 12'h001 >= hold_reg) begin
					stable_next[i] = rawIn[i]; // R14
					count_next[i] = '0;
				end else begin
					count_next[i] = count_reg[i] + 12'h001;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			stable_reg <= '0;
			for (int i = 0; i < acif_pkg::POINTS; i++)
				count_reg[i] <= '0;
		end else begin
			stable_reg <= stable_next;
			for (int i = 0; i < acif_pkg::POINTS; i++)
				count_reg[i] <= count_next[i];
		end
	end

	// terminal block presence and messages
	logic tbPrev_reg, tbPrev_next;
	logic tbEvent_reg, tbEvent_next;
	logic tbAttach_reg, tbAttach_next;

	always_comb begin
		tbPrev_next = tbLatched;
		tbEvent_next = tbLatched != tbPrev_reg; // R12
		tbAttach_next = tbAttach_reg;
		if (tbLatched != tbPrev_reg)
			tbAttach_next = tbLatched; // R12
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			tbPrev_reg <= 1'b0;
			tbEvent_reg <= 1'b0;
			tbAttach_reg <= 1'b0;
		end else begin
			tbPrev_reg <= tbPrev_next;
			tbEvent_reg <= tbEvent_next;
			tbAttach_reg <= tbAttach_next;
		end
	end

	// readiness and status word
	logic booting_reg, booting_next;
	logic [15:0] status_reg, status_next;

	always_comb begin
		logic notReady;
		notReady = 1'b0;
		booting_next = booting_reg && !msTick_reg;
		notReady = booting_reg || (link.filterLen == acif_pkg::LEN_ON && !haveSetting_reg);
		status_next = '0;
		if (link.statusLen == acif_pkg::LEN_ON) begin // R8
			status_next[acif_pkg::STAT_NOT_READY] = notReady; // R10
			status_next[acif_pkg::STAT_TB_ABSENT] = !tbPrev_reg; // R9
		end
		status_next[15:acif_pkg::STAT_USED] = '0; // R9
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			booting_reg <= 1'b1;
			status_reg <= '0;
		end else begin
			booting_reg <= booting_next;
			status_reg <= status_next;
		end
	end

	// indicators
	logic green_reg, green_next;
	logic red_reg, red_next;

	always_comb begin
		green_next = tbLatched; // R11
		red_next = !tbLatched; // R11
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			green_reg <= 1'b0;
			red_reg <= 1'b1;
		end else begin
			green_reg <= green_next;
			red_reg <= red_next;
		end
	end

	assign pointLed = stable_reg; // R13
	assign tbLedGreen = green_reg;
	assign tbLedRed = red_reg;
	assign link.inputState = stable_reg;
	assign link.statusWord = status_reg;
	assign link.tbEvent = tbEvent_reg;
	assign link.tbAttach = tbAttach_reg;

endmodule

// >>> acif_link_if.sv
interface acif_link_if;
	logic [4:0] filterLen;
	logic [4:0] statusLen;
	logic [6:0] filterSetting;
	logic settingValid;
	logic [31:0] inputState;
	logic [15:0] statusWord;
	logic tbEvent;
	logic tbAttach;
	modport device (
		input filterLen,
		input statusLen,
		input filterSetting,
		input settingValid,
		output inputState,
		output statusWord,
		output tbEvent,
		output tbAttach
	);
	modport ctrl (
		output filterLen,
		output statusLen,
		output filterSetting,
		output settingValid,
		input inputState,
		input statusWord,
		input tbEvent,
		input tbAttach
	);
endinterface

// >>> acif_link_properties.sv
module acif_link_properties #(
	parameter int SCAN_CYCLES = acif_pkg::SCAN_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [4:0] filterLen,
	input wire logic [4:0] statusLen,
	input wire logic [6:0] filterSetting,
	input wire logic settingValid,
	input wire logic [31:0] inputState,
	input wire logic [15:0] statusWord,
	input wire logic tbEvent,
	input wire logic tbAttach
);
	int gap_reg;
	int gap_next;
	// cycles since the last setting transfer
	always_comb begin
		gap_next = (settingValid == 1'b1) ? 0 : gap_reg + 1;
	end
	always_ff @(posedge clock) begin
		gap_reg <= rst ? 0 : gap_next;
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_filterLen;
		filterLen == 5'h10 || filterLen == 5'h00;
	endproperty
	property p_statusLen;
		statusLen == 5'h10 || statusLen == 5'h00;
	endproperty
	property p_setRange;
		filterSetting != 7'h00;
	endproperty
	property p_statOff;
		statusLen != 5'h10 && $past(statusLen) != 5'h10 |-> statusWord == 16'h0000;
	endproperty
	property p_statHigh;
		statusWord[15:11] == 5'h00;
	endproperty
	property p_tbPulse;
		tbEvent |=> !tbEvent;
	endproperty
	property p_tbHold;
		!tbEvent && !$past(rst) |-> $stable(tbAttach);
	endproperty
	property p_scanPulse;
		settingValid |=> !settingValid [*8];
	endproperty
	property p_scanGap;
		gap_reg <= SCAN_CYCLES + 1;
	endproperty
	a_filterLen: assert property (p_filterLen) else $error("filter length not 0 or 16");
	a_statusLen: assert property (p_statusLen) else $error("status length not 0 or 16");
	a_setRange: assert property (p_setRange) else $error("filter setting zero");
	a_statOff: assert property (p_statOff) else $error("status word while off");
	a_statHigh: assert property (p_statHigh) else $error("status upper bits set");
	a_tbPulse: assert property (p_tbPulse) else $error("block event too long");
	a_tbHold: assert property (p_tbHold) else $error("block kind changed alone");
	a_scanPulse: assert property (p_scanPulse) else $error("setting pulses too close");
	a_scanGap: assert property (p_scanGap) else $error("setting transfer missed");
	cover property (settingValid);
	cover property (tbEvent && tbAttach);
	cover property (tbEvent && !tbAttach);
	cover property (statusWord[0]);
endmodule

// >>> acif_pkg.sv
package acif_pkg;
	localparam int POINTS = 32;
	localparam int GROUP_SIZE = 8;
	localparam int GROUPS = 4;
	localparam int CLK_HZ = 40_000_000;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam int FILT_STEP_MS = 20;
	localparam int SET_W = 7;
	localparam logic [6:0] SET_MIN = 7'h01;
	localparam logic [6:0] SET_MAX = 7'h7F;
	localparam logic [6:0] SET_RESET = 7'h01;
	localparam logic [4:0] LEN_ON = 5'h10;
	localparam logic [4:0] LEN_OFF = 5'h00;
	localparam int CNT_W = 12;
	localparam int EXTRA_MS_0 = 840;
	localparam int EXTRA_MS_1 = 1600;
	localparam int EXTRA_MS_2 = 1920;
	localparam int AC_HZ = 60;
	localparam int AC_MS = (1000 + AC_HZ - 1) / AC_HZ;
	localparam int STAT_USED = 11;
	localparam int STAT_NOT_READY = 9;
	localparam int STAT_TB_ABSENT = 0;
	localparam int SCAN_MS = 10;
	localparam int SCAN_CYCLES = SCAN_MS * MS_CYCLES;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FILTER = 8'h04;
	localparam logic [7:0] OFS_INPUTS = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_TBEVT = 8'h10;
	localparam int CTRL_FILT_EN = 0;
	localparam int CTRL_STAT_EN = 1;
	localparam int TB_ATTACH = 0;
	localparam int TB_LOSS = 1;
	localparam int TB_PRESENT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> test_ac_input_filter_status.sv
module test_ac_input_filter_status;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MSC = 10;
	logic clock, rst, tbLatched, tbLedGreen, tbLedRed;
	logic [31:0] rawIn, pointLed, expIn, rnd, s_axi_wdata, s_axi_rdata;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int errTotal, checkCount, seed, th, seen;
	int tbQ[$];
	int sets[5] = '{1, 42, 43, 81, 127};
	acif_link_if link ();
	acif_device #(.MS_CYCLES(MSC), .AC_MS(1)) acif_device_inst (.clock, .rst, .link(link), .rawIn, .tbLatched,
		.pointLed, .tbLedGreen, .tbLedRed);
	acif_ctrl #(.SCAN_CYCLES(20)) acif_ctrl_inst (.clock, .rst, .link(link), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	acif_link_properties #(.SCAN_CYCLES(20)) acif_link_properties_inst (.clock, .rst,
		.filterLen(link.filterLen), .statusLen(link.statusLen), .filterSetting(link.filterSetting),
		.settingValid(link.settingValid), .inputState(link.inputState), .statusWord(link.statusWord),
		.tbEvent(link.tbEvent), .tbAttach(link.tbAttach));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic finishTest();
		if (errTotal == 0 && checkCount > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] seenVal, input logic [63:0] expVal);
		checkCount++;
		if (seenVal !== expVal) begin
			errTotal++;
			$display("ERROR %0t seen %h expected %h", $time, seenVal, expVal);
		end
	endtask
	task automatic waitFor(input int w);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while ((w == 0 ? s_axi_awready : w == 1 ? s_axi_bvalid : w == 2 ? s_axi_arready : s_axi_rvalid) !== 1'b1
			&& n < 2000);
		if (n >= 2000) begin
			errTotal++;
			$display("ERROR %0t bus wait timed out", $time);
			finishTest();
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		waitFor(0);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		waitFor(1);
		chk(s_axi_bresp, r);
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		waitFor(2);
		s_axi_arvalid <= 1'b0;
		waitFor(3);
		chk(s_axi_rdata, d);
		chk(s_axi_rresp, r);
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask
	// extra ac cycles for a filter time in ms
	function automatic int extra(input int ms);
		return ms <= 840 ? 0 : ms <= 1600 ? 1 : ms < 1920 ? 2 : 3;
	endfunction
	initial begin
		{rst, tbLatched, rawIn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {1'b1, 81'h0};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_wstrb = 4'hf;
		{errTotal, checkCount, seed} = {32'h0, 32'h0, 32'hac99};
		repeat (8) @(posedge clock);
		chk({tbLedGreen, tbLedRed, link.inputState}, {2'b01, 32'h0});
		rst <= 1'b0;
		@(posedge clock);
		axr(acif_pkg::OFS_CTRL, 32'h0, acif_pkg::RESP_OKAY);
		axr(acif_pkg::OFS_FILTER, 32'h1, acif_pkg::RESP_OKAY);
		axr(8'h14, 32'h0, acif_pkg::RESP_SLVERR);
		axw(8'h14, 32'h5, acif_pkg::RESP_SLVERR);
		repeat (4) begin
			rawIn <= $random(seed);
			repeat (3) @(posedge clock);
			chk(link.inputState, rawIn);
			chk(pointLed, rawIn);
			axr(acif_pkg::OFS_INPUTS, rawIn, acif_pkg::RESP_OKAY);
		end
		expIn = rawIn;
		chk(link.statusWord, 32'h0);
		axw(acif_pkg::OFS_CTRL, 32'h2, acif_pkg::RESP_OKAY);
		repeat (3) @(posedge clock);
		chk(link.statusWord, 32'h1);
		axr(acif_pkg::OFS_STATUS, 32'h1, acif_pkg::RESP_OKAY);
		for (int i = 1; i >= 0; i--) begin
			tbLatched <= i[0];
			tbQ.push_back(i);
			seen = 0;
			repeat (5) begin
				@(posedge clock);
				if (link.tbEvent === 1'b1) begin
					seen++;
					chk(link.tbAttach, tbQ.size() > 0 ? tbQ.pop_front() : -1);
				end
			end
			chk(seen, 1);
			chk(tbQ.size(), 0);
			chk({tbLedGreen, tbLedRed, link.statusWord}, {i[0], !i[0], 15'h0, !i[0]});
			axr(acif_pkg::OFS_TBEVT, i ? 32'h5 : 32'h3, acif_pkg::RESP_OKAY);
		end
		axw(acif_pkg::OFS_TBEVT, 32'h3, acif_pkg::RESP_OKAY);
		axr(acif_pkg::OFS_TBEVT, 32'h0, acif_pkg::RESP_OKAY);
		axw(acif_pkg::OFS_CTRL, 32'h3, acif_pkg::RESP_OKAY);
		axw(acif_pkg::OFS_FILTER, 32'h0, acif_pkg::RESP_OKAY);
		axw(acif_pkg::OFS_FILTER, 32'h80, acif_pkg::RESP_OKAY);
		axr(acif_pkg::OFS_FILTER, 32'h1, acif_pkg::RESP_OKAY);
		repeat (50) @(posedge clock);
		rnd = $random(seed);
		rawIn <= expIn ^ rnd;
		repeat (18 * MSC) @(posedge clock);
		chk(link.inputState, expIn);
		rawIn <= expIn;
		repeat (20 * MSC + 5) @(posedge clock);
		chk(link.inputState, expIn);
		foreach (sets[k]) begin
			axw(acif_pkg::OFS_FILTER, sets[k], acif_pkg::RESP_OKAY);
			repeat (50) @(posedge clock);
			axr(acif_pkg::OFS_FILTER, sets[k], acif_pkg::RESP_OKAY);
			th = sets[k] * 20 + extra(sets[k] * 20);
			rnd = $random(seed);
			rawIn <= expIn ^ rnd;
			repeat ((th - 1) * MSC - 1) @(posedge clock);
			chk(link.inputState, expIn);
			repeat (MSC + 4) @(posedge clock);
			expIn = expIn ^ rnd;
			chk(link.inputState, expIn);
			chk(pointLed, expIn);
		end
		// mid-run reset: not ready until the first setting arrives
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		axw(acif_pkg::OFS_CTRL, 32'h3, acif_pkg::RESP_OKAY);
		axr(acif_pkg::OFS_STATUS, 32'h201, acif_pkg::RESP_OKAY);
		repeat (30) @(posedge clock);
		axr(acif_pkg::OFS_STATUS, 32'h1, acif_pkg::RESP_OKAY);
		chk({tbLedGreen, tbLedRed, pointLed}, {2'b01, expIn});
		finishTest();
	end
endmodule
